// ### rtl/pdl_loader.sv
// Program RAM download loader behind the interface memory scratchpad
`default_nettype none
module pdl_loader
   import pdl_pkg::*;
#(
   parameter int unsigned TMO_CYC = TIMEOUT_CYC
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         sw_rst_i,
   input  wire pdl_hbus_t    hbus_i,
   output logic       [7:0]  hrdata_o,
   input  wire logic         conn_req_i,
   input  wire logic         conn_mode_rom_i,
   input  wire logic         conn_code_resident_i,
   input  wire logic  [7:0]  conn_module_id_i,
   input  wire logic         conn_module_dsp_i,
   output logic              conn_stall_o,
   output logic              vec_init_o,
   output logic              busy_o,
   output pdl_sram_wr_t      ctl_wr_o,
   output pdl_sram_wr_t      dsp_wr_o
);
   pdl_state_t   st_q, st_d;
   logic [7:0]   req_q, req_d, alo_q, alo_d, ahi_q, ahi_d;
   logic [7:0]   ack_q, ack_d, save_q, save_d, crc_q, crc_d, rd_q, rd_d;
   logic [15:0]  wptr_q, wptr_d;
   logic [31:0]  word_q, word_d, tmo_q, tmo_d;
   logic [1:0]   lane_q, lane_d;
   logic         dsp_q, dsp_d, fin_q, fin_d, vdone_q, vdone_d, vec_q, vec_d;
   logic         stall_q, stall_d, busy_q, busy_d;
   pdl_sram_wr_t ctl_q, ctl_d, dsp_wq, dsp_wd;
   logic         host_wr, host_rd, need_dl, tmo_hit;
   logic         fifo_in_ready, fifo_out_valid, fifo_pop;
   logic [7:0]   fifo_byte;

   assign host_wr  = hbus_i.cs & hbus_i.wr;
   assign host_rd  = hbus_i.cs & ~hbus_i.wr;
   assign tmo_hit  = (tmo_q == 32'(TMO_CYC - 1));
   // Sequence check: ROM modes never call for a download
   // ROM mode bypass
   assign need_dl  = conn_req_i & ~conn_mode_rom_i & ~conn_code_resident_i;
   assign fifo_pop = fifo_out_valid & (st_q == ST_LOAD);

   pdl_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (host_wr && hbus_i.addr == ADR_TXBUF),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (hbus_i.wdata),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (st_q == ST_LOAD),
      .out_data_o  (fifo_byte)
   );

   always_comb begin
      st_d    = st_q;
      req_d   = req_q;
      alo_d   = alo_q;
      ahi_d   = ahi_q;
      ack_d   = ack_q;
      save_d  = save_q;
      crc_d   = crc_q;
      wptr_d  = wptr_q;
      word_d  = word_q;
      lane_d  = lane_q;
      dsp_d   = dsp_q;
      fin_d   = fin_q;
      vdone_d = 1'b1;
      vec_d   = ~vdone_q | sw_rst_i;
      stall_d = need_dl;
      ctl_d   = '0;
      dsp_wd  = '0;
      tmo_d   = (st_q == ST_IDLE || host_wr) ? '0 : tmo_q + 32'h1;
      rd_d    = rd_q;
      if (host_rd) begin
         unique case (hbus_i.addr)
            ADR_REQ:     rd_d = req_q;
            ADR_ADDR_LO: rd_d = alo_q;
            ADR_ADDR_HI: rd_d = ahi_q;
            ADR_ACK:     rd_d = ack_q;
            ADR_STATUS:  rd_d = 8'(fifo_in_ready) << STAT_TX_FIFO_NOT_FULL_BIT;
            default:     rd_d = 8'h00;
         endcase
      end
      if (host_wr && hbus_i.addr == ADR_ADDR_LO) begin
         alo_d = hbus_i.wdata;
      end
      if (host_wr && hbus_i.addr == ADR_ADDR_HI) begin
         ahi_d = hbus_i.wdata;
      end
      if (host_wr && hbus_i.addr == ADR_ACK) begin
         ack_d = hbus_i.wdata;
      end
      if (host_wr && hbus_i.addr == ADR_REQ) begin
         req_d = hbus_i.wdata;
      end
      if (fifo_pop) begin
         crc_d = {crc_q[6:0], crc_q[7]} + fifo_byte;
         if (!dsp_q) begin
            ctl_d  = '{we: 1'b1, addr: wptr_q, data: {24'h0, fifo_byte}};
            wptr_d = wptr_q + 16'h1;
         end else begin
            word_d[8*lane_q +: 8] = fifo_byte;
            lane_d = lane_q + 2'h1;
            if (lane_q == LAST_LANE) begin
               dsp_wd = '{we: 1'b1, addr: wptr_q, data: word_d};
               wptr_d = wptr_q + 16'h1;
            end
         end
      end
      unique case (st_q)
         ST_IDLE: begin
            // Host request in any idle moment
            if (host_wr && hbus_i.addr == ADR_REQ &&
                (hbus_i.wdata == CODE_CTL || hbus_i.wdata == CODE_DSP)) begin
               dsp_d  = (hbus_i.wdata == CODE_DSP);
               save_d = ack_q;
               ack_d  = hbus_i.wdata;
               crc_d  = CRC_INIT;
               st_d   = ST_ADDR;
            end else if (need_dl && !host_wr) begin
               req_d  = conn_module_id_i;
               alo_d  = ADDR_UNSET;
               ahi_d  = ADDR_UNSET;
               dsp_d  = conn_module_dsp_i;
               save_d = ack_q;
               crc_d  = CRC_INIT;
               st_d   = ST_ADDR;
            end
         end
         ST_ADDR: begin
            if (host_wr && hbus_i.addr == ADR_ADDR_HI) begin
               // High byte comes last, so it arms the transfer
               wptr_d = {hbus_i.wdata, alo_q};
               lane_d = '0;
               fin_d  = 1'b0;
               st_d   = ST_LOAD;
            end else if (host_wr && hbus_i.addr == ADR_REQ &&
                         hbus_i.wdata == CODE_NONE) begin
               ack_d = save_q;
               st_d  = ST_IDLE;
            end
         end
         ST_LOAD: begin
            if (host_wr && hbus_i.addr == ADR_REQ && hbus_i.wdata == CODE_NONE) begin
               fin_d = 1'b1;
            end
            // Bytes queued before the end code are still drained
            if (fin_q && !fifo_out_valid) begin
               st_d = ST_FIN;
            end
         end
         ST_FIN: begin
            ahi_d = DONE_MARK;
            alo_d = crc_q;
            ack_d = save_q;
            fin_d = 1'b0;
            st_d  = ST_IDLE;
         end
      endcase
      if ((st_q == ST_ADDR || st_q == ST_LOAD) && tmo_hit && !host_wr) begin
         req_d = CODE_NONE;
         ack_d = save_q;
         fin_d = 1'b0;
         st_d  = ST_IDLE;
      end
      // Soft reset abandons any transfer
      if (sw_rst_i) begin
         req_d = CODE_NONE;
         fin_d = 1'b0;
         st_d  = ST_IDLE;
      end
      // Registered copy of the state test, so busy_o is a flop output
      busy_d  = (st_d != ST_IDLE);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q    <= ST_IDLE;
         req_q   <= REG_RESET;
         alo_q   <= REG_RESET;
         ahi_q   <= REG_RESET;
         ack_q   <= REG_RESET;
         save_q  <= REG_RESET;
         crc_q   <= CRC_INIT;
         rd_q    <= REG_RESET;
         wptr_q  <= '0;
         word_q  <= '0;
         lane_q  <= '0;
         tmo_q   <= '0;
         dsp_q   <= 1'b0;
         fin_q   <= 1'b0;
         vdone_q <= 1'b0;
         vec_q   <= 1'b0;
         stall_q <= 1'b0;
         busy_q  <= 1'b0;
         ctl_q   <= '0;
         dsp_wq  <= '0;
      end else begin
         st_q    <= st_d;
         req_q   <= req_d;
         alo_q   <= alo_d;
         ahi_q   <= ahi_d;
         ack_q   <= ack_d;
         save_q  <= save_d;
         crc_q   <= crc_d;
         rd_q    <= rd_d;
         wptr_q  <= wptr_d;
         word_q  <= word_d;
         lane_q  <= lane_d;
         tmo_q   <= tmo_d;
         dsp_q   <= dsp_d;
         fin_q   <= fin_d;
         vdone_q <= vdone_d;
         vec_q   <= vec_d;
         stall_q <= stall_d;
         busy_q  <= busy_d;
         ctl_q   <= ctl_d;
         dsp_wq  <= dsp_wd;
      end
   end

   assign hrdata_o     = rd_q;
   assign conn_stall_o = stall_q;
   assign vec_init_o   = vec_q;
   assign busy_o       = busy_q;
   assign ctl_wr_o     = ctl_q;
   assign dsp_wr_o     = dsp_wq;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   a_ack_copy : assert property (
      st_q == ST_IDLE && host_wr && hbus_i.addr == ADR_REQ && hbus_i.wdata == CODE_CTL
      && !sw_rst_i |=> ack_q == CODE_CTL && st_q == ST_ADDR && !dsp_q)
      else $error("control request not acknowledged");
   a_dsp_target : assert property (
      st_q == ST_IDLE && host_wr && hbus_i.addr == ADR_REQ && hbus_i.wdata == CODE_DSP
      && !sw_rst_i |=> dsp_q && ack_q == CODE_DSP)
      else $error("dsp request not taken");
   a_addr_arm : assert property (
      st_q == ST_ADDR && host_wr && hbus_i.addr == ADR_ADDR_HI && !sw_rst_i
      |=> st_q == ST_LOAD && wptr_q == {$past(hbus_i.wdata), $past(alo_q)})
      else $error("start address not loaded");
   a_dev_request : assert property (
      st_q == ST_IDLE && need_dl && !host_wr && !sw_rst_i
      |=> req_q == $past(conn_module_id_i) && alo_q == ADDR_UNSET && ahi_q == ADDR_UNSET)
      else $error("device request not presented");
   a_crc_step : assert property (
      fifo_pop |=> crc_q == 8'({$past(crc_q[6:0]), $past(crc_q[7])} + $past(fifo_byte)))
      else $error("checksum step wrong");
   a_ctl_write : assert property (
      fifo_pop && !dsp_q
      |=> ctl_wr_o.we && ctl_wr_o.data[7:0] == $past(fifo_byte) && wptr_q == ctl_wr_o.addr + 16'h1)
      else $error("control byte not written");
   a_fin_marks : assert property (
      st_q == ST_FIN && !sw_rst_i |=> ahi_q == DONE_MARK && alo_q == $past(crc_q) && st_q == ST_IDLE)
      else $error("completion marks wrong");
   a_timeout : assert property (
      (st_q == ST_ADDR || st_q == ST_LOAD) && tmo_hit && !host_wr
      |=> req_q == CODE_NONE && st_q == ST_IDLE)
      else $error("timeout did not abort");
   a_rom_nostall : assert property (
      conn_mode_rom_i |=> !conn_stall_o)
      else $error("stall in a rom mode");
   a_vec_reset : assert property (
      sw_rst_i |=> vec_init_o)
      else $error("vectors not reloaded");

   c_ctl_load  : cover property (st_q == ST_FIN && !dsp_q);
   c_dsp_word  : cover property (dsp_wr_o.we);
   c_dev_req   : cover property (st_q == ST_IDLE && need_dl ##1 st_q == ST_ADDR);
   c_fifo_full : cover property (host_wr && hbus_i.addr == ADR_TXBUF && !fifo_in_ready);
endmodule
`default_nettype wire

// ### inc/pdl_pkg.sv
// Constants, types and carriers of the program RAM download loader
// Summary of operation
// - Two program SRAMs: control and DSP
// - Request code 4Fh loads control SRAM
// - Request code 5Fh loads DSP SRAM
// - Load address: high 17h, low 16h
// - Device writes wanted module ID at 14h
// - Host requests accepted only while idle
// - Missing mode code: request it, stall sequence
// - Resets reload default intercept vectors
// - ROM modes run without any download
// - Checksum: rotate left, add byte
// - Absorb one byte per clock
// - Readiness: request code copied to 1Bh
// - Host writes bytes while not-full flag set
// - Code 00 ends: 17h=FFh, 16h=checksum
// - Thirty second stall aborts, clears request
`default_nettype none
package pdl_pkg;
   localparam logic [7:0]  ADR_STATUS     = 8'h0D;
   localparam logic [7:0]  ADR_TXBUF      = 8'h10;
   localparam logic [7:0]  ADR_REQ        = 8'h14;
   localparam logic [7:0]  ADR_ADDR_LO    = 8'h16;
   localparam logic [7:0]  ADR_ADDR_HI    = 8'h17;
   localparam logic [7:0]  ADR_ACK        = 8'h1B;
   localparam int          STAT_TX_FIFO_NOT_FULL_BIT = 1;
   localparam logic [7:0]  CODE_CTL       = 8'h4F;
   localparam logic [7:0]  CODE_DSP       = 8'h5F;
   localparam logic [7:0]  CODE_NONE      = 8'h00;
   localparam logic [7:0]  DONE_MARK      = 8'hFF;
   localparam logic [7:0]  ADDR_UNSET     = 8'hFF;
   localparam logic [7:0]  CRC_INIT       = 8'h00;
   localparam logic [7:0]  REG_RESET      = 8'h00;
   localparam logic [1:0]  LAST_LANE      = 2'h3;
   localparam int          FIFO_DEPTH     = 4;
   localparam int          TIMEOUT_S      = 30;
   localparam int          CLK_HZ         = 20_000_000;
   localparam int          TIMEOUT_CYC    = TIMEOUT_S * CLK_HZ;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ADDR = 4'b0010,
      ST_LOAD = 4'b0100,
      ST_FIN  = 4'b1000
   } pdl_state_t;

   typedef struct packed {
      logic       cs;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pdl_hbus_t;

   typedef struct packed {
      logic        we;
      logic [15:0] addr;
      logic [31:0] data;
   } pdl_sram_wr_t;
endpackage
`default_nettype wire

// ### rtl/pdl_fifo.sv
// Small synchronous FIFO between the transmit data buffer and the SRAM writer
`default_nettype none
module pdl_fifo
   import pdl_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             push, pop;

   assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o  = mem_q[rp_q];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always_comb begin
      wp_d  = push ? ((wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1) : wp_q;
      rp_d  = pop ? ((rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1) : rp_q;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage has no reset; only entries that the count marks as occupied are ever read
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wp_q] <= in_data_i;
      end
   end

   a_fifo_no_over : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count past depth");
endmodule
`default_nettype wire

// ### verif/pdl_host_model.sv
// Host processor model driving the scratchpad bus of the loader
`default_nettype none
module pdl_host_model
   import pdl_pkg::*;
(
   input  wire logic       clk_i,
   output var  pdl_hbus_t  hbus_o,
   input  wire logic [7:0] hrdata_i
);
   timeunit 1ns;
   timeprecision 1ps;

   initial hbus_o = '0;

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      hbus_o <= '{cs: 1'b1, wr: 1'b1, addr: a, wdata: d};
      @(posedge clk_i);
      // Idle lines flip so a stale address is never mistaken for a live one
      hbus_o <= '{cs: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      hbus_o <= '{cs: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge clk_i);
      hbus_o <= '{cs: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hFF};
      @(posedge clk_i);
      d = hrdata_i;
   endtask

   // Bounded poll; ok drops if the value never shows
   task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                       inout bit ok);
      logic [7:0] v;
      int         n;
      n = 0;
      do begin
         rd(a, v);
         n++;
      end while (((v & m) !== e) && n < 40);
      if ((v & m) !== e) ok = 1'b0;
   endtask

   task automatic load(input bit host, input logic [7:0] code, input logic [15:0] adr,
                       input logic [7:0] b[$], output logic [7:0] crc, output bit ok);
      ok = 1'b1;
      if (host) begin
         wr(ADR_REQ, code);
         poll(ADR_ACK, 8'hFF, code, ok);
      end
      wr(ADR_ADDR_LO, adr[7:0]);
      wr(ADR_ADDR_HI, adr[15:8]);
      foreach (b[i]) begin
         // module bytes only, when not full
         poll(ADR_STATUS, 8'h02, 8'h02, ok);
         wr(ADR_TXBUF, b[i]);
      end
      wr(ADR_REQ, CODE_NONE);
      poll(ADR_ADDR_HI, 8'hFF, DONE_MARK, ok);
      rd(ADR_ADDR_LO, crc);
   endtask

   // Name of the file information descriptor, read as a little-endian word
   localparam logic [31:0] INFO_NAME = 32'h6F66_6E69;

   function automatic logic [31:0] le(input logic [7:0] f[$], input int p, input int n);
      logic [31:0] v;
      v = '0;
      for (int i = n - 1; i >= 0; i--) v = {v[23:0], f[p + i]};
      return v;
   endfunction

   task automatic load_file(input bit host, input logic [7:0] f[$], output logic [7:0] crc,
                            output bit ok);
      logic [7:0] b[$];
      int         d;
      int         n;
      int         p;
      bit         dsp;
      bit         good;
      // Magic text and at least one descriptor
      good = (le(f, 0, 4) == 32'h4D41_5244) && (le(f, 6, 2) != 0);
      // Descriptors follow the eight header bytes
      d = 8;
      // Info module is stepped over, never loaded
      if (le(f, d + 28, 4) == INFO_NAME) d = int'(le(f, d + 24, 4));
      dsp = (le(f, d + 4, 2) == 32'h8000);
      n = int'(le(f, d + 16, 4)) * (dsp ? 4 : 1);
      p = int'(le(f, d + 20, 4));
      for (int i = 0; i < n; i++) b.push_back(f[p + i]);
      // Start address taken least significant byte first
      load(host, dsp ? CODE_DSP : CODE_CTL, 16'(le(f, d + 8, 4)), b, crc, ok);
      // Returned checksum must match the descriptor
      ok = ok && good && (crc == f[d + 6]);
   endtask
endmodule
`default_nettype wire

// ### verif/pdl_loader_bench.sv
// Self-checking bench of the program RAM download loader
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module pdl_loader_bench
   import pdl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // Short stall limit keeps the abort case quick
   localparam int unsigned TMO = 50;

   logic         clk_i    = 1'b0;
   logic         rst_n_i  = 1'b0;
   logic         sw_rst_i = 1'b0;
   logic         conn_req = 1'b0;
   logic         conn_rom = 1'b0;
   logic         conn_res = 1'b0;
   logic         conn_dsp = 1'b0;
   logic [7:0]   conn_id  = 8'h00;
   pdl_hbus_t    hbus;
   logic [7:0]   hrdata;
   logic         stall;
   logic         vec_init;
   logic         busy;
   pdl_sram_wr_t ctl_wr;
   pdl_sram_wr_t dsp_wr;
   int           errors   = 0;
   int           n_tests  = 0;
   int           vec_cnt  = 0;
   logic [31:0]  rng      = 32'h3;
   logic [15:0]  next_adr = 16'h0100;
   logic [23:0]  ctl_q[$];
   logic [47:0]  dsp_q[$];
   logic [23:0]  ce;
   logic [47:0]  de;
   logic [7:0]   regs[5]  = '{ADR_REQ, ADR_ADDR_LO, ADR_ADDR_HI, ADR_ACK, 8'h20};

   always #25 clk_i = ~clk_i;

   pdl_loader #(.TMO_CYC(TMO)) i_dut (
      .clk_i               (clk_i),
      .rst_n_i             (rst_n_i),
      .sw_rst_i            (sw_rst_i),
      .hbus_i              (hbus),
      .hrdata_o            (hrdata),
      .conn_req_i          (conn_req),
      .conn_mode_rom_i     (conn_rom),
      .conn_code_resident_i(conn_res),
      .conn_module_id_i    (conn_id),
      .conn_module_dsp_i   (conn_dsp),
      .conn_stall_o        (stall),
      .vec_init_o          (vec_init),
      .busy_o              (busy),
      .ctl_wr_o            (ctl_wr),
      .dsp_wr_o            (dsp_wr)
   );

   pdl_host_model i_host (
      .clk_i   (clk_i),
      .hbus_o  (hbus),
      .hrdata_i(hrdata)
   );

   function automatic logic [31:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   function automatic logic [7:0] crc8(input logic [7:0] b[$]);
      logic [7:0] c;
      c = 8'h00;
      foreach (b[i]) c = {c[6:0], c[7]} + b[i];
      return c;
   endfunction

   function automatic void put(ref logic [7:0] f[$], input logic [31:0] v, input int n);
      for (int i = 0; i < n; i++) f.push_back(v[8*i +: 8]);
   endfunction

   // File: header, info and code descriptors
   function automatic void make_file(input bit dsp, input logic [15:0] adr,
                                     input logic [7:0] b[$], output logic [7:0] f[$]);
      logic [31:0] u;
      // Length and end count DSP words, not bytes
      u = 32'(dsp ? b.size() / 4 : b.size());
      f = {};
      // Magic text, version 1, two descriptors
      put(f, 32'h4D41_5244, 4);
      put(f, 32'h0002_0001, 4);
      for (int d = 0; d < 2; d++) begin
         put(f, 32'(d), 4);
         put(f, dsp ? 32'h8000 : 32'h0000, 2);
         put(f, 32'(crc8(b)), 2);
         put(f, 32'(adr), 4);
         put(f, 32'(adr) + u - 32'h1, 4);
         put(f, u, 4);
         // Data at byte 74, second descriptor at byte 41
         put(f, 32'd74, 4);
         put(f, d ? 32'h0 : 32'd41, 4);
         put(f, d ? 32'h6564_6F63 : 32'h6F66_6E69, 4);
         put(f, 32'h0, 1);
      end
      foreach (b[i]) f.push_back(b[i]);
   endfunction

   // Every SRAM write must match the next expected unit of its own region
   always @(posedge clk_i) begin
      if (vec_init === 1'b1) vec_cnt++;
      if (ctl_wr.we === 1'b1) begin
         ce = (ctl_q.size() != 0) ? ctl_q.pop_front() : 24'hX;
         `CHK({ctl_wr.addr, ctl_wr.data[7:0]}, ce)
      end
      if (dsp_wr.we === 1'b1) begin
         de = (dsp_q.size() != 0) ? dsp_q.pop_front() : 48'hX;
         `CHK({dsp_wr.addr, dsp_wr.data}, de)
      end
   end

   task automatic done(input string name);
      $display("test %s finished, errors so far %0d", name, errors);
   endtask

   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic run_load(input bit dsp, input bit host, input int n);
      logic [7:0]  b[$];
      logic [31:0] r;
      logic [15:0] adr;
      logic [7:0]  crc;
      bit          ok;
      logic [7:0]  f[$];
      r = rnd();
      // Each module gets a fresh address range
      adr = next_adr + 16'(r[7:0]);
      next_adr = adr + 16'(n);
      for (int i = 0; i < n; i++) begin
         r = rnd();
         b.push_back(r[7:0]);
         if (!dsp) ctl_q.push_back({adr + 16'(i), r[7:0]});
         else if (i % 4 == 3) dsp_q.push_back({adr + 16'(i / 4), r[7:0], b[i-1], b[i-2], b[i-3]});
      end
      make_file(dsp, adr, b, f);
      i_host.load_file(host, f, crc, ok);
      `CHK(ok, 1'b1)
      `CHK(crc, crc8(b))
      `CHK(ctl_q.size() + dsp_q.size(), 0)
      `CHK(busy, 1'b0)
      done(dsp ? "dsp load" : "ctl load");
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      wrap_up();
   end

   initial begin
      logic [7:0]  v;
      logic [31:0] r;
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK(vec_cnt, 1)
      foreach (regs[i]) begin
         i_host.rd(regs[i], v);
         `CHK(v, REG_RESET)
      end
      i_host.rd(ADR_STATUS, v);
      `CHK(v[STAT_TX_FIFO_NOT_FULL_BIT], 1'b1)
      for (int i = 1; i < 4; i++) begin
         r = rnd();
         i_host.wr(regs[i], r[7:0]);
         i_host.rd(regs[i], v);
         `CHK(v, r[7:0])
      end
      done("reset and registers");
      // Corner lengths first: one control byte, then a single DSP word
      // Startup loads precede any connection request
      for (int k = 0; k < 6; k++) begin
         r = rnd();
         run_load(k[0], 1'b1, (k == 0) ? 1 : (k == 1) ? 4 : k[0] ? 4 * (2 + r[1:0]) : 1 + r[2:0]);
      end
      r = rnd();
      @(posedge clk_i);
      conn_id  <= r[7:0] | 8'h01;
      conn_dsp <= 1'b1;
      conn_req <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK(stall, 1'b1)
      i_host.rd(ADR_REQ, v);
      `CHK(v, r[7:0] | 8'h01)
      i_host.rd(ADR_ADDR_HI, v);
      `CHK(v, ADDR_UNSET)
      conn_req <= 1'b0;
      run_load(1'b1, 1'b0, 12);
      `CHK(stall, 1'b0)
      conn_rom <= 1'b1;
      conn_req <= 1'b1;
      repeat (4) @(posedge clk_i);
      `CHK(stall, 1'b0)
      `CHK(busy, 1'b0)
      conn_rom <= 1'b0;
      conn_res <= 1'b1;
      repeat (4) @(posedge clk_i);
      `CHK(stall, 1'b0)
      `CHK(busy, 1'b0)
      conn_req <= 1'b0;
      conn_res <= 1'b0;
      done("device request");
      i_host.wr(ADR_REQ, CODE_CTL);
      @(posedge clk_i);
      sw_rst_i <= 1'b1;
      @(posedge clk_i);
      sw_rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      `CHK(vec_cnt, 2)
      `CHK(busy, 1'b0)
      i_host.rd(ADR_REQ, v);
      `CHK(v, CODE_NONE)
      done("software reset");
      i_host.wr(ADR_ACK, r[7:0]);
      i_host.wr(ADR_REQ, CODE_CTL);
      i_host.wr(ADR_REQ, CODE_NONE);
      @(posedge clk_i);
      `CHK(busy, 1'b0)
      i_host.rd(ADR_ACK, v);
      `CHK(v, r[7:0])
      done("address abort");
      i_host.wr(ADR_REQ, CODE_DSP);
      repeat (TMO + 10) @(posedge clk_i);
      `CHK(busy, 1'b0)
      i_host.rd(ADR_REQ, v);
      `CHK(v, CODE_NONE)
      done("stall abort");
      // Final control load stands for the vector module
      run_load(1'b0, 1'b1, 4);
      wrap_up();
   end
endmodule
`default_nettype wire
